// ### rtl/ssc_pkg.sv
// Contract
// - master data write starts clock and data
// - single mode: transfer end event, then read
// - event source: transfer end or buffer empty
// - write while buffer full overwrites data
// - buffered period read returns pending transmit
// - timing select writable during operation
// - slave shifts on external serial clock
// - overrun is the only detected error
// - word length seven or eight bits
// - slave rate at most operation clock/6
// - data phase: output at or before clock
// - clock phase bit inverts serial clock
// - stop trigger clears channel running status
// - clock gate off resets whole unit
package ssc_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 8;             // register data width
  localparam int unsigned ADDR_W = 3;             // register address width

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA   = 3'h0;      // channel_data_reg
  localparam logic [2:0] ADDR_MODE   = 3'h1;      // mode and phase bits
  localparam logic [2:0] ADDR_STATUS = 3'h2;      // channel_status_reg
  localparam logic [2:0] ADDR_CTRL   = 3'h3;      // start / stop triggers
  localparam logic [2:0] ADDR_DIV    = 3'h4;      // master half-period

  // ------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------
  localparam int unsigned MODE_IRQ_TIMING = 0;    // 1 = buffer empty event
  localparam int unsigned MODE_SLAVE      = 1;    // 1 = external clock
  localparam int unsigned MODE_LEN8       = 2;    // 1 = 8 bit, 0 = 7 bit
  localparam int unsigned MODE_DAP        = 3;    // data_phase_select
  localparam int unsigned MODE_CKP        = 4;    // clock_phase_select
  localparam int unsigned MODE_LSB_FIRST  = 5;    // data direction
  localparam int unsigned MODE_OUT_EN     = 6;    // serial_output_enable
  localparam int unsigned MODE_OUT_LEVEL  = 7;    // serial_data_level

  // ------------------------------------------------------------
  // status and control fields
  // ------------------------------------------------------------
  localparam int unsigned STAT_OVERRUN  = 0;      // write 1 clears
  localparam int unsigned STAT_BUF_FULL = 1;      // buffer_full_flag
  localparam int unsigned STAT_BUSY     = 2;      // transfer_in_progress
  localparam int unsigned STAT_RUNNING  = 3;      // channel_running_status
  localparam int unsigned CTRL_START    = 0;      // write 1 to start
  localparam int unsigned CTRL_STOP     = 1;      // stop_trigger_bit

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RESET   = 8'h84;    // 8 bit, output idles high
  localparam logic [7:0] DIV_RESET    = 8'h04;    // master half-period, cycles
  localparam logic [7:0] TX_FILL      = 8'hff;    // slave shift with no data
  localparam logic [3:0] LAST_EDGE_8  = 4'hf;     // 16 edges per 8-bit word
  localparam logic [3:0] LAST_EDGE_7  = 4'hd;     // 14 edges per 7-bit word

  // ------------------------------------------------------------
  // shifter phase
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    PH_IDLE  = 1'b0,
    PH_SHIFT = 1'b1
  } ssc_phase_type;

endpackage

// ### rtl/ssc_sync2.sv
module ssc_sync2
  import ssc_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("ssc_sync2: WIDTH must be at least 1");
  end

  // two stages; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;    // first stage
    logic [WIDTH-1:0] stable;  // second stage
  } ssc_sync_type;

  ssc_sync_type s_reg;         // registered state
  ssc_sync_type s_next;        // next state

  // next-state copy
  always_comb begin
    s_next        = s_reg;
    s_next.meta   = async_in;
    s_next.stable = s_reg.meta;
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule

// ### rtl/ssc_clk_div.sv
module ssc_clk_div
  import ssc_pkg::*;
#(
  parameter int unsigned DIV_W = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] half_cycles,
  // one-cycle pulse each half period of the serial clock
  output logic                  tick
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (DIV_W < 2) begin : g_bad_width
    $error("ssc_clk_div: DIV_W must be at least 2");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;     // cycles into the half period
    logic             tick;    // registered pulse
  } ssc_div_type;

  ssc_div_type d_reg;          // registered state
  ssc_div_type d_next;         // next state
  logic [DIV_W-1:0] limit;     // terminal count

  // a zero setting acts as one, so the clock never stalls
  always_comb begin
    limit  = (half_cycles == '0) ? '0 : half_cycles - 1'b1;
    d_next = d_reg;
    d_next.tick = 1'b0;
    if (!run) begin
      // restart cleanly so every word gets full half periods
      d_next.cnt = '0;
    end else if (d_reg.cnt >= limit) begin
      d_next.cnt  = '0;
      d_next.tick = 1'b1;
    end else begin
      d_next.cnt = d_reg.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign tick = d_reg.tick;

endmodule

// ### rtl/ssc_channel.sv
module ssc_channel
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // unit clock supply; low holds the channel in reset
  input  wire logic              peripheral_clock_gate,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // event to the interrupt controller
  output logic                   channel_irq,
  // serial clock pin, two-way
  input  wire logic              serial_clock_pin_in,
  output logic                   serial_clock_pin_out,
  output logic                   serial_clock_pin_oe,
  // serial data pins
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    ssc_phase_type phase;      // shifter idle or busy
    logic          running;    // channel_running_status
    logic [7:0]    mode;       // mode and phase bits
    logic [7:0]    div;        // master half-period
    logic [7:0]    tx_buf;     // serial_io_buffer, transmit side
    logic          buf_full;   // buffer_full_flag
    logic [7:0]    rx_data;    // last received word
    logic          rx_valid;   // received word not yet read
    logic          overrun;    // overrun_flag
    logic [7:0]    tx_sh;      // transmit shifter
    logic [7:0]    rx_sh;      // receive shifter
    logic [3:0]    ecnt;       // serial clock edges in this word
    logic          sck_lvl;    // normalised master clock, idles high
    logic          nclk_q;     // last normalised slave clock level
    logic          so_lvl;     // serial output level
    logic          sck_pin;    // clock pin drive level
    logic          irq;        // one-cycle event
    logic [7:0]    rdata;      // read data, cycle after the strobe
  } ssc_state_type;

  localparam ssc_state_type RESET_STATE = '{
    phase:    PH_IDLE,
    running:  1'b0,
    mode:     MODE_RESET,
    div:      DIV_RESET,
    tx_buf:   8'h00,
    buf_full: 1'b0,
    rx_data:  8'h00,
    rx_valid: 1'b0,
    overrun:  1'b0,
    tx_sh:    8'h00,
    rx_sh:    8'h00,
    ecnt:     4'h0,
    sck_lvl:  1'b1,
    nclk_q:   1'b1,
    so_lvl:   1'b1,
    sck_pin:  1'b1,
    irq:      1'b0,
    rdata:    8'h00
  };

  ssc_state_type r_reg;        // registered state
  ssc_state_type r_next;       // next state

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [1:0] pin_sync;        // synchronised clock and data inputs
  logic       sck_s;           // synchronised serial clock
  logic       si_s;            // synchronised serial data in
  logic       div_tick;        // master half-period pulse
  logic       is_slave;        // external clock mode
  logic       nclk;            // slave clock, normalised to idle high
  logic       lead;            // first edge of each bit
  logic       trail;           // second edge of each bit
  logic       done;            // last edge of the word seen
  logic       wr_data;         // decoded data write
  logic       wr_mode;         // decoded mode write
  logic       wr_stat;         // decoded status write
  logic       wr_ctrl;         // decoded control write
  logic       wr_div;          // decoded divider write

  // external pins cross into clk_sys before anything looks at them
  ssc_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in ({serial_clock_pin_in, serial_in_pin}),
    .sync_out (pin_sync)
  );

  assign sck_s    = pin_sync[1];
  assign si_s     = pin_sync[0];
  assign is_slave = r_reg.mode[MODE_SLAVE];

  // master clock generator runs only while a word is shifting
  ssc_clk_div #(
    .DIV_W (8)
  ) u_div (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .run         (r_reg.running && !is_slave && (r_reg.phase == PH_SHIFT)),
    .half_cycles (r_reg.div),
    .tick        (div_tick)
  );

  // ------------------------------------------------------------
  // shifter functions
  // ------------------------------------------------------------
  // next output bit, by data direction
  function automatic logic out_bit(input logic [7:0] sh, input logic [7:0] m);
    out_bit = m[MODE_LSB_FIRST] ? sh[0] : sh[7];
  endfunction

  // advance the transmit shifter by one bit
  function automatic logic [7:0] tx_shift(input logic [7:0] sh, input logic [7:0] m);
    tx_shift = m[MODE_LSB_FIRST] ? {1'b1, sh[7:1]} : {sh[6:0], 1'b1};
  endfunction

  // take a word into the shifter; a 7-bit word is left-aligned for msb first
  function automatic ssc_state_type load_word(input ssc_state_type s,
                                              input logic [7:0]    d);
    ssc_state_type t;
    t       = s;
    t.tx_sh = (!s.mode[MODE_LSB_FIRST] && !s.mode[MODE_LEN8]) ? {d[6:0], 1'b1} : d;
    t.phase = PH_SHIFT;
    t.ecnt  = 4'h0;
    t.rx_sh = 8'h00;
    // phase 1 puts the first bit out half a clock early
    if (s.mode[MODE_DAP]) begin
      t.so_lvl = out_bit(t.tx_sh, s.mode);
      t.tx_sh  = tx_shift(t.tx_sh, s.mode);
    end
    load_word = t;
  endfunction

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  // clock phase bit inverts the pin before use
  assign nclk = sck_s ^ r_reg.mode[MODE_CKP];

  // master edges come from the divider, slave edges from the pin
  always_comb begin
    if (is_slave) begin
      lead  = r_reg.nclk_q && !nclk;
      trail = !r_reg.nclk_q && nclk;
    end else begin
      lead  = div_tick && !r_reg.ecnt[0];
      trail = div_tick && r_reg.ecnt[0];
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb begin
    wr_data = 1'b0;
    wr_mode = 1'b0;
    wr_stat = 1'b0;
    wr_ctrl = 1'b0;
    wr_div  = 1'b0;
    if (!reg_write) begin
      wr_data = 1'b0;
    end else if (reg_addr == ADDR_DATA) begin
      wr_data = 1'b1;
    end else if (reg_addr == ADDR_MODE) begin
      wr_mode = 1'b1;
    end else if (reg_addr == ADDR_STATUS) begin
      wr_stat = 1'b1;
    end else if (reg_addr == ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_addr == ADDR_DIV) begin
      wr_div = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next       = r_reg;
    r_next.irq   = 1'b0;
    r_next.rdata = 8'h00;
    done         = 1'b0;
    r_next.nclk_q = nclk;

    // reads first, so a word landing this cycle keeps its valid bit
    if (reg_read) begin
      if (reg_addr == ADDR_DATA) begin
        // buffered period shows pending transmit data, shifter untouched
        r_next.rdata = r_reg.buf_full ? r_reg.tx_buf : r_reg.rx_data;
        if (!r_reg.buf_full) begin
          r_next.rx_valid = 1'b0;
        end
      end else if (reg_addr == ADDR_MODE) begin
        r_next.rdata = r_reg.mode;
      end else if (reg_addr == ADDR_STATUS) begin
        r_next.rdata[STAT_OVERRUN]  = r_reg.overrun;
        r_next.rdata[STAT_BUF_FULL] = r_reg.buf_full;
        r_next.rdata[STAT_BUSY]     = (r_reg.phase == PH_SHIFT) || r_reg.buf_full;
        r_next.rdata[STAT_RUNNING]  = r_reg.running;
      end else if (reg_addr == ADDR_DIV) begin
        r_next.rdata = r_reg.div;
      end
    end

    // overrun clear by writing 1; a new overrun below still wins
    if (wr_stat && reg_wdata[STAT_OVERRUN]) begin
      r_next.overrun = 1'b0;
    end

    // idle: take buffered data, or a slave word clocked without data
    if (r_reg.running && r_reg.phase == PH_IDLE) begin
      if (r_reg.buf_full) begin
        r_next          = load_word(r_next, r_reg.tx_buf);
        r_next.buf_full = 1'b0;
        // buffer empty event in continuous mode
        r_next.irq      = r_reg.mode[MODE_IRQ_TIMING];
      end else if (is_slave && lead) begin
        r_next = load_word(r_next, TX_FILL);
      end
    end

    // shifting: one action per serial clock edge
    if (r_reg.running && r_next.phase == PH_SHIFT && (lead || trail)) begin
      if (lead) begin
        r_next.sck_lvl = 1'b0;
      end else begin
        r_next.sck_lvl = 1'b1;
      end
      // phase 0: drive on lead, sample on trail; phase 1 the reverse
      if (lead ^ r_reg.mode[MODE_DAP]) begin
        if (!(trail && (r_next.ecnt == last_edge()))) begin
          r_next.so_lvl = out_bit(r_next.tx_sh, r_reg.mode);
          r_next.tx_sh  = tx_shift(r_next.tx_sh, r_reg.mode);
        end
      end else begin
        r_next.rx_sh = r_reg.mode[MODE_LSB_FIRST] ? {si_s, r_next.rx_sh[7:1]}
                                                  : {r_next.rx_sh[6:0], si_s};
      end
      if (r_next.ecnt == last_edge()) begin
        done = 1'b1;
      end else begin
        r_next.ecnt = r_next.ecnt + 4'h1;
      end
    end

    // word complete
    if (done) begin
      r_next.phase    = PH_IDLE;
      // 7-bit words: lsb-first sits high, msb-first low
      if (r_reg.mode[MODE_LEN8]) begin
        r_next.rx_data = r_next.rx_sh;
      end else if (r_reg.mode[MODE_LSB_FIRST]) begin
        r_next.rx_data = {1'b0, r_next.rx_sh[7:1]};
      end else begin
        r_next.rx_data = {1'b0, r_next.rx_sh[6:0]};
      end
      r_next.rx_valid = 1'b1;
      // unread word overwritten: the one error this channel detects
      if (r_next.rx_valid && r_reg.rx_valid) begin
        r_next.overrun = 1'b1;
      end
      // transfer end event in single mode
      if (!r_reg.mode[MODE_IRQ_TIMING]) begin
        r_next.irq = 1'b1;
      end
      // either mode: next buffered word follows with no gap; event here in continuous mode
      if (r_next.buf_full) begin
        r_next          = load_word(r_next, r_next.tx_buf);
        r_next.buf_full = 1'b0;
        if (r_reg.mode[MODE_IRQ_TIMING]) begin
          r_next.irq = 1'b1;
        end
      end
    end

    // data write lands last: it overwrites a full buffer
    if (wr_data) begin
      r_next.tx_buf   = reg_wdata;
      r_next.buf_full = 1'b1;
    end

    // timing select may change mid-transfer, taking effect at word end
    if (wr_mode) begin
      r_next.mode = reg_wdata;
    end
    if (wr_div) begin
      r_next.div = reg_wdata;
    end

    // start and stop; stop aborts the shifter and wins over start
    if (wr_ctrl && reg_wdata[CTRL_START]) begin
      r_next.running = 1'b1;
    end
    if (wr_ctrl && reg_wdata[CTRL_STOP]) begin
      r_next.running = 1'b0;
      r_next.phase   = PH_IDLE;
      r_next.sck_lvl = 1'b1;
    end

    // output disabled: data pin shows the software level
    if (!r_next.mode[MODE_OUT_EN]) begin
      r_next.so_lvl = r_next.mode[MODE_OUT_LEVEL];
    end
    r_next.sck_pin = r_next.sck_lvl ^ r_next.mode[MODE_CKP];

    // clock supply off clears everything
    if (!peripheral_clock_gate) begin
      r_next = RESET_STATE;
    end
  end

  // ------------------------------------------------------------
  // small combinational helpers used above
  // ------------------------------------------------------------
  // last edge index for the selected length
  function automatic logic [3:0] last_edge();
    last_edge = r_reg.mode[MODE_LEN8] ? LAST_EDGE_8 : LAST_EDGE_7;
  endfunction

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= RESET_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata            = r_reg.rdata;
  assign channel_irq          = r_reg.irq;
  assign serial_out_pin       = r_reg.so_lvl;
  assign serial_clock_pin_out = r_reg.sck_pin;
  // master drives the clock only while running; slave listens
  assign serial_clock_pin_oe  = r_reg.running && !is_slave;

endmodule

// ### verification/ssc_checker.sv
// checks on the channel's own ports
module ssc_checker
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              peripheral_clock_gate,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  // event and serial pins
  input wire logic              channel_irq,
  input wire logic              serial_clock_pin_out,
  input wire logic              serial_clock_pin_oe,
  input wire logic              serial_out_pin
);
  logic [7:0] mode_reg;    // shadow of the mode register
  logic       pin_reg;     // clock pin one cycle ago
  logic [4:0] edges_reg;   // clock pin changes since last word start
  wire  [4:0] edge_total = edges_reg + {4'h0, serial_clock_pin_out != pin_reg};

  // shadow of the mode register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg  <= MODE_RESET;
      pin_reg   <= 1'b1;
      edges_reg <= 5'h00;
    end else begin
      pin_reg <= serial_clock_pin_out;
      if (!peripheral_clock_gate) mode_reg <= MODE_RESET;
      else if (reg_write && reg_addr == ADDR_MODE) mode_reg <= reg_wdata;
      // restart the count at each event or data write
      if (channel_irq || (reg_write && reg_addr == ADDR_DATA)) edges_reg <= 5'h00;
      else if (serial_clock_pin_out != pin_reg) edges_reg <= edges_reg + 5'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_rdata_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_start_clock;
    reg_write && reg_addr == ADDR_DATA && serial_clock_pin_oe && !mode_reg[MODE_SLAVE]
      |-> ##[2:40] $changed(serial_clock_pin_out);
  endproperty
  a_start_clock: assert property (p_start_clock) else $error("data write gave no clock");
  property p_irq_pulse; channel_irq |=> !channel_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than a cycle");
  property p_word_edges;
    channel_irq && serial_clock_pin_oe && !mode_reg[MODE_IRQ_TIMING]
      |-> edge_total == (mode_reg[MODE_LEN8] ? 5'd16 : 5'd14);
  endproperty
  a_word_edges: assert property (p_word_edges) else $error("wrong clock count per word");
  property p_stop;
    reg_write && reg_addr == ADDR_CTRL && reg_wdata[CTRL_STOP] |-> ##[1:2] !serial_clock_pin_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left clock driven");
  property p_gate;
    !peripheral_clock_gate |=> !channel_irq && !serial_clock_pin_oe && serial_out_pin;
  endproperty
  a_gate: assert property (p_gate) else $error("clock gate did not reset");
  property p_slave_no_clock;
    mode_reg[MODE_SLAVE] && $past(mode_reg[MODE_SLAVE]) |-> !serial_clock_pin_oe;
  endproperty
  a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drove clock");
  property p_idle_level;
    $rose(serial_clock_pin_oe) |-> serial_clock_pin_out == !mode_reg[MODE_CKP];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");
endmodule

bind ssc_channel ssc_checker u_ssc_checker (
  .clk_sys(clk_sys), .arst_n(arst_n), .peripheral_clock_gate(peripheral_clock_gate),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .channel_irq(channel_irq), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_out_pin(serial_out_pin)
);

// ### verification/ssc_spi_partner.sv
// far-side device: drives on the leading edge, samples on the trailing edge
module ssc_spi_partner (
  // serial lines
  input  wire logic       sck,
  input  wire logic       ckp,
  input  wire logic       mosi,
  output logic            miso,
  // word to send and word received
  input  wire logic       load,
  input  wire logic [7:0] tx_word,
  output logic      [7:0] rx_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;                  // outgoing shift register
  wire        sck_norm = sck ^ ckp; // undo the selected polarity
  initial begin
    miso    = 1'b0;
    rx_word = 8'h00;
    sh      = 8'h00;
  end
  always @(posedge load) sh = tx_word;
  // refill with the inverse of the last bit
  always @(negedge sck_norm) begin
    miso <= sh[7];
    sh   <= {sh[6:0], ~sh[0]};
  end
  always @(posedge sck_norm) rx_word <= {rx_word[6:0], mosi};
endmodule

// ### verification/ssc_tb.sv
module tb
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              peripheral_clock_gate = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata, d;
  logic              channel_irq, serial_clock_pin_out, serial_clock_pin_oe, serial_out_pin;
  logic              tb_sck = 1'b1, miso, p_load = 1'b0, p_ckp = 1'b0;
  logic [7:0]        p_tx = 8'h00, p_rx;
  wire               sck_line = serial_clock_pin_oe ? serial_clock_pin_out : tb_sck;
  int                n_errors = 0, compares = 0, cycles = 0, k;

  always #2.5 clk_sys = ~clk_sys;

  ssc_channel u_ssc_channel (.clk_sys(clk_sys), .arst_n(arst_n),
    .peripheral_clock_gate(peripheral_clock_gate), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .channel_irq(channel_irq), .serial_clock_pin_in(sck_line),
    .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
    .serial_in_pin(miso), .serial_out_pin(serial_out_pin));
  ssc_spi_partner u_ssc_spi_partner (.sck(sck_line), .ckp(p_ckp), .mosi(serial_out_pin),
    .miso(miso), .load(p_load), .tx_word(p_tx), .rx_word(p_rx));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded wait for the one-cycle event
  task automatic wait_irq;
    for (int i = 0; i < 400 && channel_irq !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(channel_irq, 1'b1)
  endtask
  task automatic pload(input logic [7:0] v);
    p_tx = v;
    p_load = 1'b1;
    #1 p_load = 1'b0;
  endtask
  // eight external clocks at 48 ns, idle high between frames
  task automatic slave_frame;
    repeat (16) #24 tb_sck = ~tb_sck;
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict;
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADDR_MODE, d);
    `CHK(d, MODE_RESET)
    rd(3'h7, d);
    `CHK(d, 8'h00)
    // single transfers, both clock polarities
    for (k = 0; k < 2; k++) begin
      p_ckp = k[0];
      wr(ADDR_MODE, {3'b010, k[0], 4'h4});
      wr(ADDR_CTRL, 8'h01);
      pload(k[0] ? 8'hc3 : 8'h3c);
      wr(ADDR_DATA, 8'ha5);
      wait_irq;
      `CHK(p_rx, 8'ha5)
      rd(ADDR_DATA, d);
      `CHK(d, (k[0] ? 8'hc3 : 8'h3c))
      wr(ADDR_CTRL, 8'h02);
    end
    // continuous: buffer empty events, overwrite, pending read, overrun
    p_ckp = 1'b0;
    wr(ADDR_MODE, 8'h45);
    wr(ADDR_CTRL, 8'h01);
    pload(8'h00);
    wr(ADDR_DATA, 8'h11);
    wait_irq;
    wr(ADDR_DATA, 8'h22);
    wr(ADDR_DATA, 8'h33);
    rd(ADDR_DATA, d);
    `CHK(d, 8'h33)
    wait_irq;
    `CHK(p_rx, 8'h11)
    wr(ADDR_MODE, 8'h44);
    wait_irq;
    `CHK(p_rx, 8'h33)
    rd(ADDR_STATUS, d);
    `CHK(d[STAT_OVERRUN], 1'b1)
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, d);
    `CHK(d[STAT_OVERRUN], 1'b0)
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_STATUS, d);
    `CHK(d[STAT_RUNNING], 1'b0)
    // seven-bit word, then a stop in mid word
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_DATA, 8'h55);
    wait_irq;
    `CHK(p_rx[6:0], 7'h55)
    wr(ADDR_DATA, 8'h0f);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_STATUS, d);
    `CHK(d[3:2], 2'b00)
    wr(ADDR_MODE, 8'h04);
    #1 `CHK(serial_out_pin, 1'b0)
    // slave with external clock, traffic both ways
    wr(ADDR_MODE, 8'h46);
    wr(ADDR_CTRL, 8'h01);
    pload(8'h96);
    wr(ADDR_DATA, 8'hc3);
    slave_frame;
    repeat (10) @(posedge clk_sys);
    `CHK(p_rx, 8'hc3)
    rd(ADDR_DATA, d);
    `CHK(d, 8'h96)
    // clock gate drop resets the channel
    @(posedge clk_sys);
    peripheral_clock_gate <= 1'b0;
    @(posedge clk_sys);
    peripheral_clock_gate <= 1'b1;
    rd(ADDR_MODE, d);
    `CHK(d, MODE_RESET)
    give_verdict;
  end
endmodule
